// ### rtl/mcu_logic_rotate_skip_exec.sv
// Execution unit for OR, returns, rotates, subtract with borrow, set and skip instructions.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps

module mcu_logic_rotate_skip_exec #(
  parameter int PC_W = 13,
  parameter int ADDR_W = 9,
  parameter int STACK_DEPTH = 8,
  parameter logic [PC_W-1:0] IRQ_VECTOR = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic opValid,
  input wire logic [4:0] opCode,
  input wire logic [7:0] opImm,
  input wire logic [2:0] opBit,
  input wire logic [ADDR_W-1:0] opAddr,
  input wire logic [7:0] memRdata,
  input wire logic irqPending,
  output logic opReady,
  output logic instrDone,
  output logic skipTaken,
  output logic irqAck,
  output logic memWe,
  output logic [ADDR_W-1:0] memAddr,
  output logic [7:0] memWdata,
  output logic [7:0] accOut,
  output logic [5:0] flagsOut,
  output logic [PC_W-1:0] pcOut,
  output logic emiOut,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {IDLE, DUMMY, IRQ_ENTRY} state_e;

  state_e state_ff;
  logic [7:0] acc_ff;
  logic [5:0] flags_ff;
  logic [PC_W-1:0] pc_ff;
  logic emi_ff;
  logic [PC_W-1:0] stack_ff [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [PC_W-1:0] stkHi_ff;
  logic done_ff;
  logic skip_ff;
  logic irqAck_ff;
  logic memWe_ff;
  logic [ADDR_W-1:0] memAddr_ff;
  logic [7:0] memWdata_ff;
  logic [7:0] regRdata_ff;
  logic accept;
  logic takeIrq;
  logic [7:0] res;
  logic [5:0] nxt_flags;
  logic wrAcc;
  logic wrMem;
  logic skip;
  logic isRet;
  logic setEmi;
  logic [10:0] subRes;
  logic [7:0] subOp;
  logic [PC_W-1:0] popPc;

  // Difference with borrow, packed as {carry, half, overflow, result}.
  function automatic logic [10:0] subBorrow(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] full;
    logic [4:0] low;
    logic ov;
    full = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
    ov = (a[7] != b[7]) && (full[7] != a[7]);
    return {~full[8], ~low[4], ov, full[7:0]};
  endfunction

  // Rotate by one place; the vacated bit is taken from fill.
  function automatic logic [7:0] rotL(input logic [7:0] v, input logic fill);
    return {v[6:0], fill};
  endfunction

  function automatic logic [7:0] rotR(input logic [7:0] v, input logic fill);
    return {fill, v[7:1]};
  endfunction

  // A pending interrupt, while the master enable is set, holds off new requests so it is entered first.
  assign takeIrq = (state_ff == IDLE) && irqPending && emi_ff;
  assign opReady = (state_ff == IDLE) && !takeIrq;
  assign accept = opValid && opReady;
  assign subOp = (opCode == mcu_exec_pkg::OP_SUB_BORROW_IMM) ? opImm : memRdata;
  assign subRes = subBorrow(acc_ff, subOp, flags_ff[mcu_exec_pkg::F_CARRY]);
  assign popPc = stack_ff[sp_ff - SP_W'(1)];

  // Instruction decode and datapath; flags start from their old values so untouched ones hold.
  always_comb begin
    res = memRdata;
    nxt_flags = flags_ff;
    wrAcc = 1'b0;
    wrMem = 1'b0;
    skip = 1'b0;
    isRet = 1'b0;
    setEmi = 1'b0;
    case (opCode)
      mcu_exec_pkg::OP_OR_IMM: begin
        res = acc_ff | opImm;
        wrAcc = 1'b1;
        nxt_flags[mcu_exec_pkg::F_ZERO] = (res == 8'h00);
      end
      mcu_exec_pkg::OP_OR_ACC: begin
        res = acc_ff | memRdata;
        wrAcc = 1'b1;
        nxt_flags[mcu_exec_pkg::F_ZERO] = (res == 8'h00);
      end
      mcu_exec_pkg::OP_OR_TO_MEM: begin
        res = acc_ff | memRdata;
        wrMem = 1'b1;
        nxt_flags[mcu_exec_pkg::F_ZERO] = (res == 8'h00);
      end
      mcu_exec_pkg::OP_RETURN: begin
        isRet = 1'b1;
      end
      mcu_exec_pkg::OP_RETURN_LIT: begin
        isRet = 1'b1;
        res = opImm;
        wrAcc = 1'b1;
      end
      mcu_exec_pkg::OP_IRQ_RETURN: begin
        isRet = 1'b1;
        setEmi = 1'b1;
      end
      mcu_exec_pkg::OP_ROT_LEFT, mcu_exec_pkg::OP_ROT_LEFT_A: begin
        res = rotL(memRdata, memRdata[7]);
        wrMem = (opCode == mcu_exec_pkg::OP_ROT_LEFT);
        wrAcc = !wrMem;
      end
      mcu_exec_pkg::OP_ROT_LEFT_C, mcu_exec_pkg::OP_ROT_LEFT_CA: begin
        res = rotL(memRdata, flags_ff[mcu_exec_pkg::F_CARRY]);
        nxt_flags[mcu_exec_pkg::F_CARRY] = memRdata[7];
        wrMem = (opCode == mcu_exec_pkg::OP_ROT_LEFT_C);
        wrAcc = !wrMem;
      end
      mcu_exec_pkg::OP_ROT_RIGHT, mcu_exec_pkg::OP_ROT_RIGHT_A: begin
        res = rotR(memRdata, memRdata[0]);
        wrMem = (opCode == mcu_exec_pkg::OP_ROT_RIGHT);
        wrAcc = !wrMem;
      end
      mcu_exec_pkg::OP_ROT_RIGHT_C, mcu_exec_pkg::OP_ROT_RIGHT_CA: begin
        res = rotR(memRdata, flags_ff[mcu_exec_pkg::F_CARRY]);
        nxt_flags[mcu_exec_pkg::F_CARRY] = memRdata[0];
        wrMem = (opCode == mcu_exec_pkg::OP_ROT_RIGHT_C);
        wrAcc = !wrMem;
      end
      mcu_exec_pkg::OP_SUB_BORROW, mcu_exec_pkg::OP_SUB_BORROW_IMM, mcu_exec_pkg::OP_SUB_BORROW_MEM: begin
        res = subRes[7:0];
        wrMem = (opCode == mcu_exec_pkg::OP_SUB_BORROW_MEM);
        wrAcc = !wrMem;
        // Chained zero only stays set while every byte of a multi-byte difference is zero.
        nxt_flags[mcu_exec_pkg::F_CARRY] = subRes[10];
        nxt_flags[mcu_exec_pkg::F_HALF] = subRes[9];
        nxt_flags[mcu_exec_pkg::F_OVF] = subRes[8];
        nxt_flags[mcu_exec_pkg::F_ZERO] = (subRes[7:0] == 8'h00);
        nxt_flags[mcu_exec_pkg::F_SIGN] = subRes[8] ^ subRes[7];
        nxt_flags[mcu_exec_pkg::F_CHZ] = (subRes[7:0] == 8'h00) && flags_ff[mcu_exec_pkg::F_CHZ];
      end
      mcu_exec_pkg::OP_DEC_SKIP, mcu_exec_pkg::OP_DEC_SKIP_A: begin
        res = memRdata - 8'h01;
        wrMem = (opCode == mcu_exec_pkg::OP_DEC_SKIP);
        wrAcc = !wrMem;
        skip = (res == 8'h00);
      end
      mcu_exec_pkg::OP_INC_SKIP, mcu_exec_pkg::OP_INC_SKIP_A: begin
        res = memRdata + 8'h01;
        wrMem = (opCode == mcu_exec_pkg::OP_INC_SKIP);
        wrAcc = !wrMem;
        skip = (res == 8'h00);
      end
      mcu_exec_pkg::OP_SET_BYTE: begin
        res = mcu_exec_pkg::ALL_ONES;
        wrMem = 1'b1;
      end
      mcu_exec_pkg::OP_SET_BIT: begin
        res = memRdata | (8'h01 << opBit);
        wrMem = 1'b1;
      end
      mcu_exec_pkg::OP_BIT_SKIP_NZ: begin
        skip = memRdata[opBit];
      end
      mcu_exec_pkg::OP_BYTE_SKIP_NZ: begin
        res = memRdata;
        wrMem = 1'b1;
        skip = (memRdata != 8'h00);
      end
      default: begin
        // Unknown codes retire as a single-cycle no-operation.
      end
    endcase
  end

  // Sequencer: returns and taken skips add a dummy slot, a pending interrupt gets an entry slot.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= IDLE;
    end else if (takeIrq) begin
      state_ff <= IRQ_ENTRY;
    end else if (accept && (skip || isRet)) begin
      state_ff <= DUMMY;
    end else begin
      state_ff <= IDLE;
    end
  end

  // Completion, skip and interrupt-entry pulses.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      skip_ff <= 1'b0;
      irqAck_ff <= 1'b0;
    end else begin
      done_ff <= (accept && !(skip || isRet)) || (state_ff == DUMMY);
      skip_ff <= accept && skip;
      irqAck_ff <= takeIrq;
    end
  end

  // Accumulator: instruction results take priority over a software write in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= mcu_exec_pkg::ACC_RST;
    end else if (accept && wrAcc) begin
      acc_ff <= res;
    end else if (regWr && regAddr == mcu_exec_pkg::REG_ACC) begin
      acc_ff <= regWdata;
    end
  end

  // Status flags.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= mcu_exec_pkg::FLAGS_RST;
    end else if (accept) begin
      flags_ff <= nxt_flags;
    end else if (regWr && regAddr == mcu_exec_pkg::REG_STATUS) begin
      flags_ff <= regWdata[5:0];
    end
  end

  // Master interrupt enable: hardware set beats a software clear, entry clears it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      emi_ff <= mcu_exec_pkg::EMI_RST;
    end else if (accept && setEmi) begin
      emi_ff <= 1'b1;
    end else if (takeIrq) begin
      emi_ff <= 1'b0;
    end else if (regWr && regAddr == mcu_exec_pkg::REG_CTRL) begin
      emi_ff <= regWdata[mcu_exec_pkg::CTRL_EMI];
    end
  end

  // Program counter: one step, two steps past a skipped instruction, a pop, or the vector.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_ff <= '0;
    end else if (takeIrq) begin
      pc_ff <= IRQ_VECTOR;
    end else if (accept && isRet) begin
      pc_ff <= popPc;
    end else if (accept) begin
      pc_ff <= pc_ff + (skip ? PC_W'(2) : PC_W'(1));
    end else if (regWr && regAddr == mcu_exec_pkg::REG_PC_LO) begin
      pc_ff <= {pc_ff[PC_W-1:8], regWdata};
    end else if (regWr && regAddr == mcu_exec_pkg::REG_PC_HI) begin
      pc_ff <= {regWdata[PC_W-9:0], pc_ff[7:0]};
    end
  end

  // Staged upper bits for a software push of a full return address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stkHi_ff <= '0;
    end else if (regWr && regAddr == mcu_exec_pkg::REG_STK_HI) begin
      stkHi_ff <= {regWdata[PC_W-9:0], 8'h00};
    end
  end

  // Stack pointer wraps; overflow overwrites the oldest entry, as a circular stack does.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_ff <= '0;
    end else if (takeIrq) begin
      sp_ff <= sp_ff + SP_W'(1);
    end else if (accept && isRet) begin
      sp_ff <= sp_ff - SP_W'(1);
    end else if (regWr && regAddr == mcu_exec_pkg::REG_STK_PUSH) begin
      sp_ff <= sp_ff + SP_W'(1);
    end
  end

  // Stack storage needs no reset; only the pointer defines which entries are live.
  always_ff @(posedge clk) begin
    if (takeIrq) begin
      stack_ff[sp_ff] <= pc_ff;
    end else if (!(accept && isRet) && regWr && regAddr == mcu_exec_pkg::REG_STK_PUSH) begin
      stack_ff[sp_ff] <= {stkHi_ff[PC_W-1:8], regWdata};
    end
  end

  // Data memory write-back port, registered one cycle after the request is taken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memWe_ff <= 1'b0;
      memAddr_ff <= '0;
      memWdata_ff <= 8'h00;
    end else begin
      memWe_ff <= accept && wrMem;
      if (accept && wrMem) begin
        memAddr_ff <= opAddr;
        memWdata_ff <= res;
      end
    end
  end

  // Register reads; unmapped addresses read as zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata_ff <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        mcu_exec_pkg::REG_ACC: regRdata_ff <= acc_ff;
        mcu_exec_pkg::REG_STATUS: regRdata_ff <= {2'b00, flags_ff};
        mcu_exec_pkg::REG_PC_LO: regRdata_ff <= pc_ff[7:0];
        mcu_exec_pkg::REG_PC_HI: regRdata_ff <= 8'(pc_ff[PC_W-1:8]);
        mcu_exec_pkg::REG_CTRL: regRdata_ff <= {7'h00, emi_ff};
        mcu_exec_pkg::REG_STK_PUSH: regRdata_ff <= 8'(sp_ff);
        default: regRdata_ff <= 8'h00;
      endcase
    end else begin
      regRdata_ff <= 8'h00;
    end
  end

  assign instrDone = done_ff;
  assign skipTaken = skip_ff;
  assign irqAck = irqAck_ff;
  assign memWe = memWe_ff;
  assign memAddr = memAddr_ff;
  assign memWdata = memWdata_ff;
  assign accOut = acc_ff;
  assign flagsOut = flags_ff;
  assign pcOut = pc_ff;
  assign emiOut = emi_ff;
  assign regRdata = regRdata_ff;
endmodule

// ### rtl/mcu_exec_pkg.sv
// Constants shared by the logic, rotate, subtract and skip execution unit.
package mcu_exec_pkg;
  localparam int DATA_W = 8;
  localparam int OPC_W = 5;
  localparam int REG_AW = 3;
  // Instruction codes presented on the request port.
  localparam logic [4:0] OP_OR_IMM = 5'h00;
  localparam logic [4:0] OP_OR_ACC = 5'h01;
  localparam logic [4:0] OP_OR_TO_MEM = 5'h02;
  localparam logic [4:0] OP_RETURN = 5'h03;
  localparam logic [4:0] OP_RETURN_LIT = 5'h04;
  localparam logic [4:0] OP_IRQ_RETURN = 5'h05;
  localparam logic [4:0] OP_ROT_LEFT = 5'h06;
  localparam logic [4:0] OP_ROT_LEFT_A = 5'h07;
  localparam logic [4:0] OP_ROT_LEFT_C = 5'h08;
  localparam logic [4:0] OP_ROT_LEFT_CA = 5'h09;
  localparam logic [4:0] OP_ROT_RIGHT = 5'h0a;
  localparam logic [4:0] OP_ROT_RIGHT_A = 5'h0b;
  localparam logic [4:0] OP_ROT_RIGHT_C = 5'h0c;
  localparam logic [4:0] OP_ROT_RIGHT_CA = 5'h0d;
  localparam logic [4:0] OP_SUB_BORROW = 5'h0e;
  localparam logic [4:0] OP_SUB_BORROW_IMM = 5'h0f;
  localparam logic [4:0] OP_SUB_BORROW_MEM = 5'h10;
  localparam logic [4:0] OP_DEC_SKIP = 5'h11;
  localparam logic [4:0] OP_DEC_SKIP_A = 5'h12;
  localparam logic [4:0] OP_INC_SKIP = 5'h13;
  localparam logic [4:0] OP_INC_SKIP_A = 5'h14;
  localparam logic [4:0] OP_SET_BYTE = 5'h15;
  localparam logic [4:0] OP_SET_BIT = 5'h16;
  localparam logic [4:0] OP_BIT_SKIP_NZ = 5'h17;
  localparam logic [4:0] OP_BYTE_SKIP_NZ = 5'h18;
  // Status flag bit positions.
  localparam int FLAG_W = 6;
  localparam int F_CARRY = 0;
  localparam int F_HALF = 1;
  localparam int F_ZERO = 2;
  localparam int F_OVF = 3;
  localparam int F_SIGN = 4;
  localparam int F_CHZ = 5;
  localparam int CTRL_EMI = 0;
  // Register port addresses.
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_PC_LO = 3'h2;
  localparam logic [2:0] REG_PC_HI = 3'h3;
  localparam logic [2:0] REG_CTRL = 3'h4;
  localparam logic [2:0] REG_STK_HI = 3'h5;
  localparam logic [2:0] REG_STK_PUSH = 3'h6;
  // Reset values.
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic EMI_RST = 1'b0;
  localparam logic [7:0] ALL_ONES = 8'hff;
  // Instruction cycle counts.
  localparam int CYC_PLAIN = 1;
  localparam int CYC_LONG = 2;
endpackage

// ### verification/mcu_exec_asserts.sv
// Checker on the execution port of the logic, rotate and skip unit.
`timescale 1ns/1ps
module exec_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic opValid,
  input wire logic opReady,
  input wire logic [4:0] opCode,
  input wire logic [7:0] opImm,
  input wire logic [7:0] memRdata,
  input wire logic irqPending,
  input wire logic instrDone,
  input wire logic skipTaken,
  input wire logic irqAck,
  input wire logic memWe,
  input wire logic [7:0] memWdata,
  input wire logic [7:0] accOut,
  input wire logic [5:0] flagsOut,
  input wire logic emiOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // A request only counts on an edge where the unit is ready for it.
  wire take = opValid && opReady;
  sequence s_dec_hit;
    take && opCode == mcu_exec_pkg::OP_DEC_SKIP && memRdata == 8'h01;
  endsequence
  sequence s_interrupt_return;
    take && opCode == mcu_exec_pkg::OP_IRQ_RETURN;
  endsequence
  property p_or_imm;
    logic [7:0] v;
    logic [5:0] f;
    (take && opCode == mcu_exec_pkg::OP_OR_IMM, v = accOut | opImm, f = flagsOut) |=>
      accOut == v && flagsOut == {f[5:3], v == 8'h00, f[1:0]};
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("OR immediate wrong");
  property p_rot_left;
    logic [7:0] v;
    (take && opCode == mcu_exec_pkg::OP_ROT_LEFT, v = {memRdata[6:0], memRdata[7]}) |=>
      memWe && memWdata == v && $stable(flagsOut);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("Rotate left wrong");
  property p_rotc_left_acc;
    logic [7:0] v;
    logic c;
    (take && opCode == mcu_exec_pkg::OP_ROT_LEFT_CA, v = {memRdata[6:0], flagsOut[0]}, c = memRdata[7]) |=>
      accOut == v && flagsOut[0] == c && !memWe;
  endproperty
  a_rotc_left_acc: assert property (p_rotc_left_acc) else $error("Carry rotate to acc wrong");
  property p_rotc_right;
    logic [7:0] v;
    logic c;
    (take && opCode == mcu_exec_pkg::OP_ROT_RIGHT_C, v = {flagsOut[0], memRdata[7:1]}, c = memRdata[0]) |=>
      memWe && memWdata == v && flagsOut[0] == c;
  endproperty
  a_rotc_right: assert property (p_rotc_right) else $error("Carry rotate right wrong");
  property p_skip;
    s_dec_hit |=> skipTaken && !instrDone && memWe && memWdata == 8'h00 ##1 instrDone;
  endproperty
  a_skip: assert property (p_skip) else $error("Decrement skip wrong");
  property p_set_byte;
    take && opCode == mcu_exec_pkg::OP_SET_BYTE |=>
      instrDone && !skipTaken && memWe && memWdata == 8'hff && $stable(flagsOut);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("Byte set wrong");
  property p_interrupt_return;
    s_interrupt_return |=> emiOut ##1 instrDone;
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("Interrupt return wrong");
  property p_irq_first;
    s_interrupt_return ##0 irqPending ##1 irqPending [*2] |->
      instrDone ##1 irqAck && !emiOut;
  endproperty
  a_irq_first: assert property (p_irq_first) else $error("Pending interrupt not taken");
  property p_dummy_busy;
    s_dec_hit or s_interrupt_return |=> !opReady;
  endproperty
  a_dummy_busy: assert property (p_dummy_busy) else $error("Request accepted in dummy slot");
endmodule

// ### verification/mcu_logic_rotate_skip_exec_test.sv
// Self-checking bench for the logic, rotate, subtract and skip unit.
`timescale 1ns/1ps
module mcu_logic_rotate_skip_exec_test;
  typedef struct packed {logic [7:0] a; logic [5:0] f; logic we; logic [7:0] w; logic sk;} res_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic opValid = 1'b0;
  logic [4:0] opCode = 5'h00;
  logic [7:0] opImm = 8'h00;
  logic [2:0] opBit = 3'h0;
  logic [8:0] opAddr = 9'h000;
  logic [7:0] memRdata = 8'h00;
  logic irqPending = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic opReady, instrDone, skipTaken, irqAck, memWe, emiOut, emiE;
  logic [8:0] memAddr;
  logic [7:0] memWdata, accOut, regRdata, accE;
  logic [5:0] flagsOut, flagsE;
  logic [12:0] pcOut, pcE;
  int errCount = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 77335;

  mcu_logic_rotate_skip_exec DUT (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode), .opImm(opImm),
    .opBit(opBit), .opAddr(opAddr), .memRdata(memRdata), .irqPending(irqPending), .opReady(opReady),
    .instrDone(instrDone), .skipTaken(skipTaken), .irqAck(irqAck), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .accOut(accOut), .flagsOut(flagsOut), .pcOut(pcOut), .emiOut(emiOut),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clk = ~clk;

  // The run needs a few hundred cycles, so this ceiling only trips on a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      giveVerdict();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic giveVerdict();
    $display("Checks %0d, mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One register strobe; read data are valid right after the edge that takes the read.
  task automatic regOp(input logic wr, input logic [2:0] a, input logic [7:0] d);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
  endtask

  // Upper return bits are staged first; the low byte completes the push.
  task automatic push(input logic [12:0] p);
    regOp(1'b1, mcu_exec_pkg::REG_STK_HI, {3'b000, p[12:8]});
    regOp(1'b1, mcu_exec_pkg::REG_STK_PUSH, p[7:0]);
  endtask

  // Expected outcome of one instruction; t says whether acc, memory or neither takes v.
  function automatic res_s model(input logic [4:0] op, input logic [7:0] a, input logic [5:0] f,
                                 input logic [7:0] m, input logic [7:0] i, input logic [2:0] b);
    res_s r;
    logic [1:0] t;
    logic [7:0] v;
    logic [7:0] s;
    logic [8:0] d;
    logic [4:0] h;
    logic ov;
    s = op == mcu_exec_pkg::OP_SUB_BORROW_IMM ? i : m;
    d = {1'b0, a} - {1'b0, s} - {8'h00, !f[0]};
    h = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, !f[0]};
    ov = (a[7] ^ s[7]) & (d[7] ^ a[7]);
    case (op)
      mcu_exec_pkg::OP_OR_IMM: {t, v} = {2'b10, a | i};
      mcu_exec_pkg::OP_OR_ACC: {t, v} = {2'b10, a | m};
      mcu_exec_pkg::OP_OR_TO_MEM: {t, v} = {2'b01, a | m};
      mcu_exec_pkg::OP_RETURN_LIT: {t, v} = {2'b10, i};
      mcu_exec_pkg::OP_ROT_LEFT: {t, v} = {2'b01, m[6:0], m[7]};
      mcu_exec_pkg::OP_ROT_LEFT_A: {t, v} = {2'b10, m[6:0], m[7]};
      mcu_exec_pkg::OP_ROT_LEFT_C: {t, v} = {2'b01, m[6:0], f[0]};
      mcu_exec_pkg::OP_ROT_LEFT_CA: {t, v} = {2'b10, m[6:0], f[0]};
      mcu_exec_pkg::OP_ROT_RIGHT: {t, v} = {2'b01, m[0], m[7:1]};
      mcu_exec_pkg::OP_ROT_RIGHT_A: {t, v} = {2'b10, m[0], m[7:1]};
      mcu_exec_pkg::OP_ROT_RIGHT_C: {t, v} = {2'b01, f[0], m[7:1]};
      mcu_exec_pkg::OP_ROT_RIGHT_CA: {t, v} = {2'b10, f[0], m[7:1]};
      mcu_exec_pkg::OP_SUB_BORROW, mcu_exec_pkg::OP_SUB_BORROW_IMM: {t, v} = {2'b10, d[7:0]};
      mcu_exec_pkg::OP_SUB_BORROW_MEM: {t, v} = {2'b01, d[7:0]};
      mcu_exec_pkg::OP_DEC_SKIP: {t, v} = {2'b01, m - 8'h01};
      mcu_exec_pkg::OP_DEC_SKIP_A: {t, v} = {2'b10, m - 8'h01};
      mcu_exec_pkg::OP_INC_SKIP: {t, v} = {2'b01, m + 8'h01};
      mcu_exec_pkg::OP_INC_SKIP_A: {t, v} = {2'b10, m + 8'h01};
      mcu_exec_pkg::OP_SET_BYTE: {t, v} = {2'b01, mcu_exec_pkg::ALL_ONES};
      mcu_exec_pkg::OP_SET_BIT: {t, v} = {2'b01, m | (8'h01 << b)};
      mcu_exec_pkg::OP_BIT_SKIP_NZ: {t, v} = {2'b00, m};
      mcu_exec_pkg::OP_BYTE_SKIP_NZ: {t, v} = {2'b01, m};
      default: {t, v} = {2'b00, m};
    endcase
    r.a = t[1] ? v : a;
    r.we = t[0];
    r.w = v;
    r.f = f;
    if (op inside {[mcu_exec_pkg::OP_OR_IMM:mcu_exec_pkg::OP_OR_TO_MEM]})
      r.f[2] = v == 8'h00;
    if (op inside {[mcu_exec_pkg::OP_ROT_LEFT_C:mcu_exec_pkg::OP_ROT_LEFT_CA]})
      r.f[0] = m[7];
    if (op inside {[mcu_exec_pkg::OP_ROT_RIGHT_C:mcu_exec_pkg::OP_ROT_RIGHT_CA]})
      r.f[0] = m[0];
    if (op inside {[mcu_exec_pkg::OP_SUB_BORROW:mcu_exec_pkg::OP_SUB_BORROW_MEM]})
      r.f = {d[7:0] == 8'h00 && f[5], ov ^ d[7], ov, d[7:0] == 8'h00, !h[4], !d[8]};
    r.sk = op == mcu_exec_pkg::OP_BIT_SKIP_NZ ? m[b] : op == mcu_exec_pkg::OP_BYTE_SKIP_NZ ? m != 8'h00 :
           op inside {[mcu_exec_pkg::OP_DEC_SKIP:mcu_exec_pkg::OP_INC_SKIP_A]} && v == 8'h00;
    return r;
  endfunction

  // Issues one instruction when the unit is ready, then compares every visible effect.
  task automatic run(input logic [4:0] op, input logic [7:0] imm, input logic [2:0] b, input logic [7:0] m,
                     input logic [12:0] popPc);
    res_s e;
    logic [8:0] ad;
    logic ret;
    ad = 9'($random(seed));
    ret = op inside {mcu_exec_pkg::OP_RETURN, mcu_exec_pkg::OP_RETURN_LIT, mcu_exec_pkg::OP_IRQ_RETURN};
    e = model(op, accE, flagsE, m, imm, b);
    while (opReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    opValid <= 1'b1;
    opCode <= op;
    opImm <= imm;
    opBit <= b;
    opAddr <= ad;
    memRdata <= m;
    @(posedge clk);
    opValid <= 1'b0;
    memRdata <= ~m;
    #1;
    accE = e.a;
    flagsE = e.f;
    pcE = ret ? popPc : pcE + (e.sk ? 13'h0002 : 13'h0001);
    emiE = emiE || op == mcu_exec_pkg::OP_IRQ_RETURN;
    check("acc", accOut, accE);
    check("flags", flagsOut, flagsE);
    check("pc", pcOut, pcE);
    check("emi", emiOut, emiE);
    check("skip", skipTaken, e.sk);
    check("done", instrDone, !(e.sk || ret));
    check("memWe", memWe, e.we);
    check("ready", opReady, !(e.sk || ret));
    if (e.we === 1'b1) begin
      check("memData", memWdata, e.w);
      check("memAddr", memAddr, ad);
    end
    if (e.sk || ret) begin
      @(posedge clk);
      #1;
      check("lateDone", instrDone, 1'b1);
    end
  endtask

  // Reset, random traffic over corner bytes, then returns and a pending interrupt.
  initial begin
    logic [7:0] x;
    logic [4:0] op;
    logic [12:0] p [4];
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    accE = mcu_exec_pkg::ACC_RST;
    flagsE = mcu_exec_pkg::FLAGS_RST;
    pcE = 13'h0000;
    emiE = mcu_exec_pkg::EMI_RST;
    check("accRst", accOut, accE);
    check("flagsRst", flagsOut, flagsE);
    for (int k = 0; k < 100; k++) begin
      op = 5'(k % 25);
      if (op inside {mcu_exec_pkg::OP_RETURN, mcu_exec_pkg::OP_RETURN_LIT, mcu_exec_pkg::OP_IRQ_RETURN})
        continue;
      accE = 8'($random(seed));
      flagsE = 6'($random(seed));
      regOp(1'b1, mcu_exec_pkg::REG_ACC, accE);
      regOp(1'b1, mcu_exec_pkg::REG_STATUS, {2'b00, flagsE});
      x = k % 4 == 0 ? 8'h01 : k % 4 == 1 ? 8'hff : k % 4 == 2 ? 8'h00 : 8'($random(seed));
      run(op, 8'($random(seed)), 3'($random(seed)), x, pcE);
    end
    // An unused code must still retire in one cycle and leave all state but the PC step alone.
    run(5'h1f, 8'h00, 3'h0, 8'h00, pcE);
    regOp(1'b0, mcu_exec_pkg::REG_ACC, 8'h00);
    check("readAcc", regRdata, accE);
    regOp(1'b0, 3'h7, 8'h00);
    check("readGap", regRdata, 8'h00);
    for (int i = 0; i < 4; i++) begin
      p[i] = 13'($random(seed));
      push(p[i]);
    end
    run(mcu_exec_pkg::OP_RETURN, 8'h00, 3'h0, 8'h00, p[3]);
    run(mcu_exec_pkg::OP_RETURN_LIT, 8'h5a, 3'h0, 8'h00, p[2]);
    run(mcu_exec_pkg::OP_IRQ_RETURN, 8'h00, 3'h0, 8'h00, p[1]);
    regOp(1'b1, mcu_exec_pkg::REG_CTRL, 8'h00);
    emiE = 1'b0;
    irqPending <= 1'b1;
    run(mcu_exec_pkg::OP_IRQ_RETURN, 8'h00, 3'h0, 8'h00, p[0]);
    @(posedge clk);
    #1;
    check("irqAck", irqAck, 1'b1);
    check("vector", pcOut, 13'h0000);
    // Entering the interrupt clears the master enable again.
    emiE = 1'b0;
    check("emiEntry", emiOut, emiE);
    irqPending <= 1'b0;
    run(mcu_exec_pkg::OP_RETURN, 8'h00, 3'h0, 8'h00, p[0]);
    giveVerdict();
  end
endmodule

bind mcu_logic_rotate_skip_exec exec_checker chk (.clk(clk), .rst(rst), .opValid(opValid), .opReady(opReady),
  .opCode(opCode), .opImm(opImm), .memRdata(memRdata), .irqPending(irqPending), .instrDone(instrDone),
  .skipTaken(skipTaken), .irqAck(irqAck), .memWe(memWe), .memWdata(memWdata), .accOut(accOut),
  .flagsOut(flagsOut), .emiOut(emiOut));
